// ==== hw/nibble_alu_map.svh ====
// Constants for the nibble datapath: widths, constants and operation codes.
`ifndef NIBBLE_ALU_MAP_SVH
`define NIBBLE_ALU_MAP_SVH
`define NIB_W 4
`define XREG_W 2
`define ROW_WORDS 16
`define NIB_ZERO 4'h0
`define NIB_ONE 4'h1
`define NIB_MINUS_ONE 4'hF
`define NIB_MAX 4'hF
`define OPC_W 3
`define OPC_NOP 3'h0
`define OPC_MEM_DEC 3'h1
`define OPC_ACC_INC 3'h2
`define OPC_Y_INC 3'h3
`define OPC_ACC_DEC 3'h4
`define OPC_Y_DEC 3'h5
`define OPC_XOR_MEM 3'h6
`define OPC_NEG_ACC 3'h7
`endif

// ==== hw/nibble_alu_pkg.sv ====
// Types shared by the nibble datapath modules.
package nibble_alu_pkg;
    typedef logic [3:0] nibble_t;
    typedef enum logic [1:0] {
        FLAG_KEEP,
        FLAG_CARRY,
        FLAG_SET
    } flag_src_t;
endpackage : nibble_alu_pkg

// ==== hw/nibble_adder.sv ====
// Four-bit adder with carry out, used for all increment and decrement paths.
`timescale 1ns/1ps
`include "nibble_alu_map.svh"
module nibble_adder (
    input wire logic [`NIB_W-1:0] a,
    input wire logic [`NIB_W-1:0] b,
    input wire logic cin,
    output logic [`NIB_W-1:0] sum,
    output logic cout
);
    // The carry is the fifth bit of a widened sum.
    always_comb begin
        {cout, sum} = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    end
endmodule : nibble_adder

// ==== hw/ram_word_select.sv ====
// Picks the data-RAM word addressed jointly by the X and Y registers.
`timescale 1ns/1ps
`include "nibble_alu_map.svh"
module ram_word_select #(
    parameter int XW = `XREG_W
) (
    input wire logic [(2**XW)*`ROW_WORDS*`NIB_W-1:0] ram_flat,
    input wire logic [XW-1:0] xreg,
    input wire logic [`NIB_W-1:0] yreg,
    output logic [`NIB_W-1:0] word
);
    // Row is X, column is Y; the index is the concatenation of both.
    always_comb begin
        word = ram_flat[{xreg, yreg} * `NIB_W +: `NIB_W];
    end
endmodule : ram_word_select

// ==== hw/nibble_alu.sv ====
// Nibble datapath executing memory decrement, register increment and decrement, xor and negate.
`timescale 1ns/1ps
`include "nibble_alu_map.svh"
// =============================================================================
module nibble_alu #(
    parameter int XW = `XREG_W
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic [`OPC_W-1:0] op_code,
    input wire logic [`NIB_W-1:0] ram_rdata_row,
    input wire logic [XW-1:0] xreg,
    input wire logic [`NIB_W-1:0] yreg_load,
    input wire logic yreg_load_en,
    input wire logic [`NIB_W-1:0] acc_load,
    input wire logic acc_load_en,
    input wire logic [(2**XW)*`ROW_WORDS*`NIB_W-1:0] ram_flat,
    output logic [`NIB_W-1:0] acc_q,
    output logic [`NIB_W-1:0] yreg_q,
    output logic condition_flag_q,
    output logic [XW+`NIB_W-1:0] ram_addr_q,
    output logic ram_we_q,
    output logic done_q
);
    // =========================================================================
    // Timing
    // An operation is taken on the rising edge at which op_valid is high, and its
    // results, the flag included, stand on the registered outputs after that edge.
    // Operations may follow each other in consecutive cycles; each one sees the
    // accumulator and Y values left by the one before.
    // The RAM image is read combinationally, so it must be settled at the edge
    // that takes the operation; nothing here buffers it.
    // done_q pulses for exactly one cycle per taken operation, the no-op code
    // included, so a sequencer can count retired operations.
    // An accumulator or Y load is lost when an operation that writes the same
    // register is taken in that cycle.
    // Reset is synchronous: hold srst across at least one rising edge. The
    // accumulator, Y and the address clear, the flag comes up set, and the first
    // operation may be presented in the cycle after the releasing edge.
    // =========================================================================
    // Operand selection
    // The RAM operand is chosen combinationally from X and the registered Y value.
    nibble_alu_pkg::nibble_t mem_word;
    nibble_alu_pkg::nibble_t add_a;
    nibble_alu_pkg::nibble_t add_b;
    nibble_alu_pkg::nibble_t add_sum;
    logic add_cin;
    logic add_cout;
    logic unused_row;

    ram_word_select #(.XW(XW)) u_sel (
        .ram_flat(ram_flat),
        .xreg(xreg),
        .yreg(yreg_q),
        .word(mem_word)
    );

    // Parity of the spare input, kept only so that the input is consumed.
    assign unused_row = ^ram_rdata_row;

    // Zero test used by two flag equations.
    function automatic logic is_zero(input nibble_alu_pkg::nibble_t v);
        is_zero = (v == `NIB_ZERO);
    endfunction : is_zero

    // =========================================================================
    // Shared adder operand steering
    // One adder serves every arithmetic op, trading a mux for a second adder.
    always_comb begin
        add_a = acc_q;
        add_b = `NIB_ZERO;
        add_cin = 1'b0;
        case (op_code)
            `OPC_MEM_DEC: begin
                add_a = mem_word;
                add_b = `NIB_MINUS_ONE;
            end
            `OPC_ACC_INC: begin
                add_b = `NIB_ONE;
            end
            `OPC_Y_INC: begin
                add_a = yreg_q;
                add_b = `NIB_ONE;
            end
            `OPC_ACC_DEC: begin
                add_b = `NIB_MINUS_ONE;
            end
            `OPC_Y_DEC: begin
                add_a = yreg_q;
                add_b = `NIB_MINUS_ONE;
            end
            `OPC_NEG_ACC: begin
                add_a = ~acc_q;
                add_cin = 1'b1;
            end
            default: begin
                add_a = acc_q;
            end
        endcase
    end

    nibble_adder u_add (
        .a(add_a),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .cout(add_cout)
    );

    // =========================================================================
    // Operation classes
    // Each class function belongs to the group that owns the matching state,
    // so adding an operation means touching its class decode, the adder steering and the flag case.
    // Codes outside the classes fall through to the no-op behaviour.

    // True when the operation replaces the accumulator.
    function automatic logic writes_acc(input logic [`OPC_W-1:0] code);
        case (code)
            `OPC_MEM_DEC, `OPC_ACC_INC, `OPC_ACC_DEC, `OPC_XOR_MEM, `OPC_NEG_ACC: begin
                writes_acc = 1'b1;
            end
            default: begin
                writes_acc = 1'b0;
            end
        endcase
    endfunction : writes_acc

    // True when the operation replaces the Y register.
    function automatic logic writes_yreg(input logic [`OPC_W-1:0] code);
        case (code)
            `OPC_Y_INC, `OPC_Y_DEC: begin
                writes_yreg = 1'b1;
            end
            default: begin
                writes_yreg = 1'b0;
            end
        endcase
    endfunction : writes_yreg

    // Strobes qualified by the operation code, shared by the state groups below.
    logic take_acc;
    logic take_yreg;

    // A strobe carrying the no-op code is still taken, but moves no state.
    // Keeping these strobes apart stops a Y operation from touching the accumulator.
    always_comb begin
        take_acc = op_valid && writes_acc(op_code);
        take_yreg = op_valid && writes_yreg(op_code);
    end

    // =========================================================================
    // Accumulator group
    nibble_alu_pkg::nibble_t acc_d;

    // An operation result wins over an external load in the same cycle; the load
    // is then lost, so a sequencer that needs it must not issue both together.
    // Results wrap at four bits; no carry is kept beside the accumulator.
    always_comb begin
        acc_d = acc_q;
        if (acc_load_en) begin
            acc_d = acc_load;
        end
        if (take_acc) begin
            if (op_code == `OPC_XOR_MEM) begin
                acc_d = mem_word ^ acc_q;
            end else begin
                acc_d = add_sum;
            end
        end
    end

    // Accumulator register, cleared by reset.
    // It only ever takes acc_d, so every path into it is visible above.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            acc_q <= `NIB_ZERO;
        end else begin
            acc_q <= acc_d;
        end
    end

    // =========================================================================
    // Y register group
    nibble_alu_pkg::nibble_t yreg_d;

    // A new Y value also moves the RAM operand, but only from the next cycle on,
    // because the operand selector reads the registered Y.
    // A Y load with no Y operation in the same cycle still takes effect.
    always_comb begin
        yreg_d = yreg_q;
        if (yreg_load_en) begin
            yreg_d = yreg_load;
        end
        if (take_yreg) begin
            yreg_d = add_sum;
        end
    end

    // Y register, cleared by reset.
    // Increment and decrement wrap around through the four-bit adder sum.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            yreg_q <= `NIB_ZERO;
        end else begin
            yreg_q <= yreg_d;
        end
    end

    // =========================================================================
    // Condition flag group
    logic condition_flag_d;

    // The adder carry doubles as the not-borrow indication for the memory and Y decrements,
    // since adding F carries out exactly when the old value was nonzero.
    // Negation carries out of its plus-one step only for a zero accumulator; the
    // zero test gives the same flag without waiting on the adder's carry chain.
    always_comb begin
        condition_flag_d = condition_flag_q;
        if (op_valid) begin
            case (op_code)
                `OPC_MEM_DEC: begin
                    condition_flag_d = add_cout;
                end
                `OPC_ACC_INC: begin
                    condition_flag_d = 1'b1;
                end
                `OPC_Y_INC: begin
                    condition_flag_d = add_cout;
                end
                `OPC_ACC_DEC: begin
                    condition_flag_d = !is_zero(acc_q);
                end
                `OPC_Y_DEC: begin
                    condition_flag_d = add_cout;
                end
                `OPC_XOR_MEM: begin
                    condition_flag_d = 1'b1;
                end
                `OPC_NEG_ACC: begin
                    condition_flag_d = is_zero(acc_q);
                end
                default: begin
                    condition_flag_d = condition_flag_q;
                end
            endcase
        end
    end

    // The flag comes out of reset set; a no-op leaves it untouched.
    // Only the operation, never a load, writes the flag.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            condition_flag_q <= 1'b1;
        end else begin
            condition_flag_q <= condition_flag_d;
        end
    end

    // =========================================================================
    // Memory address and completion group
    logic [XW+`NIB_W-1:0] ram_addr_d;
    logic ram_we_d;
    logic done_d;

    // The address follows X and the registered Y every cycle, so an observer sees
    // the word that the last operation read. No operation here ever writes RAM.
    // The write strobe is a register only so that every output starts at a flip-flop.
    always_comb begin
        ram_addr_d = {xreg, yreg_q};
        ram_we_d = 1'b0;
        done_d = op_valid;
    end

    // Address, write strobe and completion pulse registers.
    // done_q follows op_valid by one edge, whatever the operation code.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ram_addr_q <= '0;
            ram_we_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            ram_addr_q <= ram_addr_d;
            ram_we_q <= ram_we_d;
            done_q <= done_d;
        end
    end

    // The spare read-data input is reduced to one bit so it is visibly consumed;
    // the operand always comes from the full RAM image instead.
    logic unused_ok;
    assign unused_ok = unused_row;
endmodule : nibble_alu

// ==== tb/nibble_alu_checker.sv ====
// Checker holding the result and flag relations of the nibble datapath.
`timescale 1ns/1ps
`include "nibble_alu_map.svh"
module nibble_alu_checker #(
    parameter int XW = `XREG_W
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic [`OPC_W-1:0] op_code,
    input wire logic [XW-1:0] xreg,
    input wire logic [(2**XW)*`ROW_WORDS*`NIB_W-1:0] ram_flat,
    input wire logic [`NIB_W-1:0] acc_q,
    input wire logic [`NIB_W-1:0] yreg_q,
    input wire logic condition_flag_q,
    input wire logic [XW+`NIB_W-1:0] ram_addr_q,
    input wire logic ram_we_q
);
    // =========================================================================
    // Operand decode.
    // The code reads as no-op without the strobe, so one compare covers both.
    logic [`OPC_W-1:0] oc;
    logic [`NIB_W-1:0] mw;
    assign oc = op_valid ? op_code : `OPC_NOP;
    assign mw = ram_flat[`NIB_W*int'({xreg, yreg_q}) +: `NIB_W];
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // =========================================================================
    // Results, one cycle after the operation is taken; the write strobe and the address are checked every cycle.
    property p_mem_dec;
        oc == `OPC_MEM_DEC |=> acc_q == $past(mw) + 4'hF
            && condition_flag_q == ($past(mw) != 4'h0);
    endproperty
    a_mem_dec: assert property (p_mem_dec) else $error("memory decrement wrong");
    property p_no_we;
        !ram_we_q;
    endproperty
    a_no_we: assert property (p_no_we) else $error("memory write seen");
    property p_acc_inc;
        oc == `OPC_ACC_INC |=> acc_q == $past(acc_q) + 4'h1 && condition_flag_q;
    endproperty
    a_acc_inc: assert property (p_acc_inc) else $error("increment wrong");
    property p_y_inc;
        oc == `OPC_Y_INC |=> yreg_q == $past(yreg_q) + 4'h1
            && condition_flag_q == ($past(yreg_q) == 4'hF);
    endproperty
    a_y_inc: assert property (p_y_inc) else $error("Y increment wrong");
    property p_acc_dec;
        oc == `OPC_ACC_DEC |=> acc_q == $past(acc_q) + 4'hF
            && condition_flag_q == ($past(acc_q) != 4'h0);
    endproperty
    a_acc_dec: assert property (p_acc_dec) else $error("decrement wrong");
    property p_y_dec;
        oc == `OPC_Y_DEC |=> yreg_q == $past(yreg_q) + 4'hF
            && condition_flag_q == ($past(yreg_q) != 4'h0);
    endproperty
    a_y_dec: assert property (p_y_dec) else $error("Y decrement wrong");
    property p_xor;
        oc == `OPC_XOR_MEM |=> acc_q == ($past(acc_q) ^ $past(mw)) && condition_flag_q;
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");
    property p_neg;
        oc == `OPC_NEG_ACC |=> acc_q == ~$past(acc_q) + 4'h1
            && condition_flag_q == ($past(acc_q) == 4'h0);
    endproperty
    a_neg: assert property (p_neg) else $error("negate wrong");
    property p_addr;
        ram_addr_q == $past({xreg, yreg_q});
    endproperty
    a_addr: assert property (p_addr) else $error("address wrong");
endmodule : nibble_alu_checker

bind nibble_alu nibble_alu_checker #(.XW(XW)) u_chk (.core_clk(core_clk), .srst(srst),
    .op_valid(op_valid), .op_code(op_code), .xreg(xreg), .ram_flat(ram_flat),
    .acc_q(acc_q), .yreg_q(yreg_q), .condition_flag_q(condition_flag_q),
    .ram_addr_q(ram_addr_q), .ram_we_q(ram_we_q));

// ==== tb/test_nibble_alu_incdec_xor_negate.sv ====
// Self-checking bench for the nibble datapath with a reference model and a result queue.
`timescale 1ns/1ps
`include "nibble_alu_map.svh"
module test_nibble_alu_incdec_xor_negate;
    logic core_clk = 1'b0;
    logic srst, op_valid, acc_load_en, yreg_load_en, fl, condition_flag_q, ram_we_q, done_q;
    logic [2:0] op_code;
    logic [1:0] xreg;
    logic [3:0] ram_rdata_row, yreg_load, acc_load, acc_q, yreg_q, ma, my;
    logic [255:0] ram_flat;
    logic [5:0] ram_addr_q;
    logic [8:0] q[$];
    int seed = 32'h1596;
    int n_mismatch = 0;
    int n_checks = 0;
    always #12.5 core_clk = ~core_clk;
    nibble_alu uut (.core_clk, .srst, .op_valid, .op_code, .ram_rdata_row, .xreg, .yreg_load,
        .yreg_load_en, .acc_load, .acc_load_en, .ram_flat, .acc_q, .yreg_q, .condition_flag_q,
        .ram_addr_q, .ram_we_q, .done_q);
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    // =========================================================================
    // Model: flags are worked out from the old value before it is replaced.
    task automatic issue(input logic [2:0] c);
        logic [3:0] m;
        m = ram_flat[4*int'({xreg, my}) +: 4];
        case (c)
            `OPC_MEM_DEC: {fl, ma} = {m != 4'h0, m + 4'hF};
            `OPC_ACC_INC: {fl, ma} = {1'b1, ma + 4'h1};
            `OPC_Y_INC: {fl, my} = {my == 4'hF, my + 4'h1};
            `OPC_ACC_DEC: {fl, ma} = {ma != 4'h0, ma + 4'hF};
            `OPC_Y_DEC: {fl, my} = {my != 4'h0, my + 4'hF};
            `OPC_XOR_MEM: {fl, ma} = {1'b1, ma ^ m};
            `OPC_NEG_ACC: {fl, ma} = {ma == 4'h0, ~ma + 4'h1};
            default: ;
        endcase
        q.push_back({ma, my, fl});
        op_code <= c;
        op_valid <= 1'b1;
    endtask : issue
    // =========================================================================
    // Each done pulse retires the oldest expectation; an unexpected pulse fails.
    always @(posedge core_clk) begin
        if (done_q === 1'b1) begin
            check({acc_q, yreg_q, condition_flag_q}, q.size() ? q.pop_front() : 9'hXXX);
        end
    end
    // =========================================================================
    // Load random operands, then two operations back to back on them.
    initial begin
        logic [9:0] r;
        {srst, op_valid, acc_load_en, yreg_load_en, fl} = 5'b10001;
        {op_code, xreg, ram_rdata_row, yreg_load, acc_load} = '0;
        for (int k = 0; k < 8; k++) ram_flat[32*k +: 32] = $random(seed);
        ram_flat[3:0] = 4'h0;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1 check({acc_q, yreg_q, condition_flag_q}, 9'h001);
        for (int i = 0; i < 300; i++) begin
            @(posedge core_clk);
            r = 10'($random(seed));
            {ma, my} = r[9:2];
            {acc_load, yreg_load, xreg} <= r;
            {op_valid, acc_load_en, yreg_load_en} <= 3'b011;
            repeat (2) begin
                @(posedge core_clk);
                {acc_load_en, yreg_load_en} <= 2'b00;
                issue(3'($random(seed)));
            end
        end
        @(posedge core_clk);
        op_valid <= 1'b0;
        for (int k = 0; k < 8 && q.size() != 0; k++) @(posedge core_clk);
        check(9'(q.size()), 9'h000);
        final_report();
    end
endmodule : test_nibble_alu_incdec_xor_negate
